// *** sdp_consts.svh ***
// Constants for the sleep, doze and idle power controller
// Assumes a 250 MHz system clock and an 8-bit register port
`ifndef SDP_CONSTS_SVH
`define SDP_CONSTS_SVH
// Overview of operation
// - Pin, brown-out and power-on events reset the device; watchdog or interrupt resumes execution
// - Every wake-up from Sleep clears the watchdog
// - Enabled pending interrupt wakes the device even with global interrupts off
// - Sleep with interrupt already pending is a no-op; status and watchdog untouched
// - Otherwise Sleep completes: clear watchdog, set timeout bit, clear powerdown bit
// - Crystal oscillator wake waits 1024 oscillator periods; other clock modes skip it
// - Interrupt wake vectors to the service routine if enabled, else continues inline
// - Regulator bit 1 selects low-power Sleep when set; resets to zero
// - Low-power Sleep adds a regulator stabilisation delay on wake-up
// - Regulator bit 0 reads one and resets one; software writes one
// - Regulator bits 7-2 and doze bit 3 read as zero
// - Idle enable makes Sleep stop only the CPU clock; reset by power-on or brown-out
// - Doze enable slows the CPU to the doze ratio; hardware or software change it
// - Recover-on-interrupt clears doze enable at service routine entry
// - Doze-on-exit sets doze enable at return from interrupt
// - Doze ratio code 0 gives 1:2, each step doubles, code 7 gives 1:256
// - Debug state forces full CPU speed without altering doze enable
// - While dozing the CPU runs one cycle in every N peripheral cycles
// - Any interrupt ends Idle even with global interrupts off; idle enable kept
// - Watchdog time-out in Sleep wakes, resumes and updates the status bits
`define SDP_ADDR_REGULATOR 4'h0
`define SDP_ADDR_DOZE      4'h1
`define SDP_ADDR_STATUS    4'h2
`define SDP_REG_PM_BIT     1
`define SDP_REG_RESET      8'h01
`define SDP_DOZE_IDLE_BIT  7
`define SDP_DOZE_EN_BIT    6
`define SDP_DOZE_ROI_BIT   5
`define SDP_DOZE_DOE_BIT   4
`define SDP_STAT_TMO_BIT   1
`define SDP_STAT_PWD_BIT   0
`define SDP_CLK_PERIOD_NS  4
`define SDP_OSC_PERIOD_NS  4
`define SDP_OST_PERIODS    1024
`define SDP_OST_CYCLES     (`SDP_OST_PERIODS * `SDP_OSC_PERIOD_NS / `SDP_CLK_PERIOD_NS)
`define SDP_STAB_TIME_NS   2000
`define SDP_STAB_CYCLES    ((`SDP_STAB_TIME_NS + `SDP_CLK_PERIOD_NS - 1) / `SDP_CLK_PERIOD_NS)
`endif

// *** sdp_core_model.sv ***
// Behavioural model of the processor core that faces the power controller
// Assumes bench requests change just after a rising clk edge
`timescale 1ns/1ns
module sdp_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sleepReq,
  input  wire logic retReq,
  input  wire logic cpuClkEn,
  input  wire logic vectorToIsr,
  output logic      sleepExec,
  output logic      isrEntry,
  output logic      retfieExec
);
  // ****************************************
  // Instruction strobes
  // ****************************************
  // The core only completes instructions while its clock runs
  always @(posedge clk) begin
    if (!rst_n) begin
      sleepExec  <= 1'b0;
      isrEntry   <= 1'b0;
      retfieExec <= 1'b0;
    end else begin
      sleepExec  <= sleepReq & cpuClkEn;
      isrEntry   <= vectorToIsr;
      retfieExec <= retReq & cpuClkEn;
    end
  end
endmodule

// *** sdp_pkg.sv ***
// Types for the sleep, doze and idle power controller
// Assumes nothing beyond the consts header
package sdp_pkg;
  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_SLEEP = 5'b00010,
    ST_IDLE  = 5'b00100,
    ST_OST   = 5'b01000,
    ST_STAB  = 5'b10000
  } sdp_state_e;
  typedef logic [10:0] sdp_count_t;
endpackage

// *** sdp_power_ctrl.sv ***
// Sleep, Idle and Doze power controller with its two control registers
// Assumes core strobes and interrupt summary on clk; reset pin is asynchronous
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "sdp_consts.svh"
module sdp_power_ctrl
  import sdp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       extResetPin_n,
  input  wire logic       brownoutEvent,
  input  wire logic       porEvent,
  input  wire logic       sleepExec,
  input  wire logic       intPending,
  input  wire logic       globalIntEnable,
  input  wire logic       watchdogTimeout,
  input  wire logic       isrEntry,
  input  wire logic       retfieExec,
  input  wire logic       inCircuitDebugState,
  input  wire logic       crystalOscMode,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  output logic            cpuClkEn,
  output logic            sysClkEn,
  output logic            cpuCycleEn,
  output logic            watchdogClear,
  output logic            timeoutStatus,
  output logic            powerdownStatus,
  output logic            vectorToIsr,
  output logic            resumeInline,
  output logic            deviceReset,
  output logic            regLowPowerSleep
);

  // ****************************************************
  // Functions
  // ****************************************************
  function automatic logic [7:0] dozeLast(input logic [2:0] code);
    dozeLast = 8'((9'h002 << code) - 9'h001);
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  sdp_state_e state;
  sdp_state_e next_state;
  sdp_count_t cnt;
  sdp_count_t next_cnt;
  logic       byInt;
  logic       next_byInt;
  logic       idleEnable;
  logic       next_idleEnable;
  logic       dozeEnable;
  logic       next_dozeEnable;
  logic       recoverOnInt;
  logic       next_recoverOnInt;
  logic       dozeOnExit;
  logic       next_dozeOnExit;
  logic [2:0] dozeRatio;
  logic [2:0] next_dozeRatio;
  logic [7:0] dozeCnt;
  logic [7:0] next_dozeCnt;
  logic       next_regLowPowerSleep;
  logic [7:0] next_regRdData;
  logic       next_cpuClkEn;
  logic       next_sysClkEn;
  logic       next_cpuCycleEn;
  logic       next_watchdogClear;
  logic       next_timeoutStatus;
  logic       next_powerdownStatus;
  logic       next_vectorToIsr;
  logic       next_resumeInline;
  logic       next_deviceReset;
  logic       pinMeta;
  logic       pinSync_n;
  logic       fullReset;
  logic       anyReset;
  logic       wake;
  logic       finish;

  // ****************************************************
  // Reset pin synchroniser
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta   <= 1'b1;
      pinSync_n <= 1'b1;
    end else begin
      pinMeta   <= extResetPin_n;
      pinSync_n <= pinMeta;
    end
  end

  assign fullReset = brownoutEvent | porEvent;
  assign anyReset  = fullReset | ~pinSync_n;
  assign wake      = intPending | watchdogTimeout;

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    next_state            = state;
    next_cnt              = cnt;
    next_byInt            = byInt;
    next_idleEnable       = idleEnable;
    next_dozeEnable       = dozeEnable;
    next_recoverOnInt     = recoverOnInt;
    next_dozeOnExit       = dozeOnExit;
    next_dozeRatio        = dozeRatio;
    next_regLowPowerSleep = regLowPowerSleep;
    next_timeoutStatus    = timeoutStatus;
    next_powerdownStatus  = powerdownStatus;
    next_watchdogClear    = 1'b0;
    next_vectorToIsr      = 1'b0;
    next_resumeInline     = 1'b0;
    next_deviceReset      = 1'b0;
    next_regRdData        = 8'h00;
    finish                = 1'b0;

    // Software access
    if (regWr) begin
      case (regAddr)
        `SDP_ADDR_REGULATOR: begin
          next_regLowPowerSleep = regWrData[`SDP_REG_PM_BIT];
        end
        `SDP_ADDR_DOZE: begin
          next_idleEnable   = regWrData[`SDP_DOZE_IDLE_BIT];
          next_dozeEnable   = regWrData[`SDP_DOZE_EN_BIT];
          next_recoverOnInt = regWrData[`SDP_DOZE_ROI_BIT];
          next_dozeOnExit   = regWrData[`SDP_DOZE_DOE_BIT];
          next_dozeRatio    = regWrData[2:0];
        end
        default: begin
        end
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `SDP_ADDR_REGULATOR: begin
          next_regRdData = {6'h00, regLowPowerSleep, 1'b1};
        end
        `SDP_ADDR_DOZE: begin
          next_regRdData = {idleEnable, dozeEnable, recoverOnInt, dozeOnExit, 1'b0, dozeRatio};
        end
        `SDP_ADDR_STATUS: begin
          next_regRdData = {6'h00, timeoutStatus, powerdownStatus};
        end
        default: begin
        end
      endcase
    end

    // Hardware edits of doze enable win over a software write
    if (isrEntry && recoverOnInt) begin
      next_dozeEnable = 1'b0;
    end
    if (retfieExec && dozeOnExit) begin
      next_dozeEnable = 1'b1;
    end

    // Sleep sequencer
    unique case (state)
      ST_RUN: begin
        if (sleepExec && !intPending) begin
          next_watchdogClear   = 1'b1;
          next_timeoutStatus   = 1'b1;
          next_powerdownStatus = 1'b0;
          next_state           = idleEnable ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_SLEEP, ST_IDLE: begin
        if (wake) begin
          next_byInt         = intPending;
          next_watchdogClear = 1'b1;
          if (!intPending) begin
            next_timeoutStatus = 1'b0;
          end
          if (state == ST_SLEEP && crystalOscMode) begin
            next_state = ST_OST;
            next_cnt   = sdp_count_t'(`SDP_OST_CYCLES - 1);
          end else if (state == ST_SLEEP && regLowPowerSleep) begin
            next_state = ST_STAB;
            next_cnt   = sdp_count_t'(`SDP_STAB_CYCLES - 1);
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_OST: begin
        next_watchdogClear = 1'b1;
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (regLowPowerSleep) begin
          next_state = ST_STAB;
          next_cnt   = sdp_count_t'(`SDP_STAB_CYCLES - 1);
        end else begin
          finish = 1'b1;
        end
      end
      ST_STAB: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          finish = 1'b1;
        end
      end
    endcase

    if (finish) begin
      next_state        = ST_RUN;
      next_vectorToIsr  = next_byInt & globalIntEnable;
      next_resumeInline = ~(next_byInt & globalIntEnable);
    end

    // Device resets override everything except read data and idle enable, which only brown-out or power-on clears
    if (anyReset) begin
      next_state            = ST_RUN;
      next_cnt              = '0;
      next_byInt            = 1'b0;
      next_dozeEnable       = 1'b0;
      next_recoverOnInt     = 1'b0;
      next_dozeOnExit       = 1'b0;
      next_dozeRatio        = 3'h0;
      next_regLowPowerSleep = 1'b0;
      next_timeoutStatus    = 1'b1;
      next_powerdownStatus  = 1'b1;
      next_watchdogClear    = 1'b1;
      next_vectorToIsr      = 1'b0;
      next_resumeInline     = 1'b0;
      next_deviceReset      = 1'b1;
      if (fullReset) begin
        next_idleEnable = 1'b0;
      end
    end

    // Clock gates and doze pacing
    next_cpuClkEn = (next_state == ST_RUN);
    next_sysClkEn = (next_state == ST_RUN) || (next_state == ST_IDLE);
    if (!next_cpuClkEn || !dozeEnable || inCircuitDebugState || dozeCnt == dozeLast(dozeRatio)) begin
      next_dozeCnt = 8'h00;
    end else begin
      next_dozeCnt = dozeCnt + 8'h01;
    end
    next_cpuCycleEn = next_cpuClkEn &&
                      (inCircuitDebugState || !next_dozeEnable || next_dozeCnt == 8'h00);
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state            <= ST_RUN;
      cnt              <= '0;
      byInt            <= 1'b0;
      idleEnable       <= 1'b0;
      dozeEnable       <= 1'b0;
      recoverOnInt     <= 1'b0;
      dozeOnExit       <= 1'b0;
      dozeRatio        <= 3'h0;
      dozeCnt          <= 8'h00;
      regLowPowerSleep <= 1'b0;
      regRdData        <= 8'h00;
      cpuClkEn         <= 1'b1;
      sysClkEn         <= 1'b1;
      cpuCycleEn       <= 1'b1;
      watchdogClear    <= 1'b1;
      timeoutStatus    <= 1'b1;
      powerdownStatus  <= 1'b1;
      vectorToIsr      <= 1'b0;
      resumeInline     <= 1'b0;
      deviceReset      <= 1'b1;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      byInt            <= next_byInt;
      idleEnable       <= next_idleEnable;
      dozeEnable       <= next_dozeEnable;
      recoverOnInt     <= next_recoverOnInt;
      dozeOnExit       <= next_dozeOnExit;
      dozeRatio        <= next_dozeRatio;
      dozeCnt          <= next_dozeCnt;
      regLowPowerSleep <= next_regLowPowerSleep;
      regRdData        <= next_regRdData;
      cpuClkEn         <= next_cpuClkEn;
      sysClkEn         <= next_sysClkEn;
      cpuCycleEn       <= next_cpuCycleEn;
      watchdogClear    <= next_watchdogClear;
      timeoutStatus    <= next_timeoutStatus;
      powerdownStatus  <= next_powerdownStatus;
      vectorToIsr      <= next_vectorToIsr;
      resumeInline     <= next_resumeInline;
      deviceReset      <= next_deviceReset;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_FULL_RESET:
    assert property (fullReset |=> deviceReset && state == ST_RUN && timeoutStatus && powerdownStatus)
    else $error("full reset did not restart the device");

  AST_WAKE_CLEARS_WATCHDOG:
    assert property ((state == ST_SLEEP || state == ST_IDLE) && wake && !anyReset |=> watchdogClear)
    else $error("wake-up did not clear the watchdog");

  AST_WAKE_GLOBAL_OFF:
    assert property (state == ST_IDLE && intPending && !globalIntEnable && !anyReset
                     |=> state == ST_RUN && resumeInline && !vectorToIsr)
    else $error("idle did not end on interrupt with global enable off");

  AST_SLEEP_AS_NOP:
    assert property (state == ST_RUN && sleepExec && intPending && !anyReset
                     |=> state == ST_RUN && !watchdogClear && $stable(timeoutStatus) && $stable(powerdownStatus))
    else $error("sleep with pending interrupt was not a no-op");

  AST_SLEEP_ENTRY:
    assert property (state == ST_RUN && sleepExec && !intPending && !anyReset
                     |=> watchdogClear && timeoutStatus && !powerdownStatus && !cpuClkEn)
    else $error("sleep entry status wrong");

  AST_START_UP_COUNT:
    assert property (state == ST_SLEEP && intPending && crystalOscMode && !anyReset
                     |=> state == ST_OST && cnt == sdp_count_t'(`SDP_OST_CYCLES - 1) && !cpuClkEn)
    else $error("start-up wait not entered");

  AST_START_UP_STEP:
    assert property (state == ST_OST && cnt != '0 && !anyReset |=> state == ST_OST && cnt == $past(cnt) - 1'b1)
    else $error("start-up counter did not step");

  AST_VECTOR:
    assert property (state == ST_SLEEP && intPending && globalIntEnable && !crystalOscMode
                     && !regLowPowerSleep && !anyReset |=> vectorToIsr && cpuClkEn)
    else $error("interrupt wake did not vector");

  AST_STABILISE:
    assert property (state == ST_OST && cnt == '0 && regLowPowerSleep && !anyReset |=> state == ST_STAB)
    else $error("low-power wake skipped stabilisation");

  AST_RESERVED_READ:
    assert property (regRd && regAddr == `SDP_ADDR_REGULATOR |=> regRdData[0] && regRdData[7:2] == 6'h00)
    else $error("regulator read shows wrong fixed bits");

  AST_RECOVER:
    assert property (isrEntry && recoverOnInt && !retfieExec && !anyReset |=> !dozeEnable)
    else $error("interrupt entry did not leave doze");

  AST_DEBUG_SPEED:
    assert property (state == ST_RUN && inCircuitDebugState && !sleepExec && !anyReset |=> cpuCycleEn)
    else $error("debug state did not force full speed");

  AST_IDLE_CLOCKS:
    assert property (state == ST_RUN && sleepExec && !intPending && idleEnable && !anyReset
                     |=> state == ST_IDLE && sysClkEn && !cpuClkEn)
    else $error("idle entry did not keep the peripheral clock");

  AST_STAB_STEP:
    assert property (state == ST_STAB && cnt != '0 && !anyReset
                     |=> state == ST_STAB && cnt == $past(cnt) - 1'b1 && !cpuClkEn)
    else $error("stabilisation counter did not step");

  AST_RETURN_DOZE:
    assert property (retfieExec && dozeOnExit && !anyReset |=> dozeEnable)
    else $error("return did not resume doze");

  AST_WATCHDOG_WAKE:
    assert property (state == ST_SLEEP && watchdogTimeout && !intPending && !crystalOscMode
                     && !regLowPowerSleep && !anyReset
                     |=> resumeInline && !timeoutStatus && !powerdownStatus && !deviceReset)
    else $error("watchdog wake status wrong");

endmodule

// *** sdp_power_ctrl_tb.sv ***
// Self-checking bench for the sleep, doze and idle power controller
// Assumes the consts header and the core model file are compiled alongside
`timescale 1ns/1ns
`include "sdp_consts.svh"
module sdp_power_ctrl_tb;
  logic clk = 0, rst_n = 0, extResetPin_n = 1, brownoutEvent = 0, porEvent = 0;
  logic intPending = 0, globalIntEnable = 0, watchdogTimeout = 0, inCircuitDebugState = 0;
  logic crystalOscMode = 0, regWr = 0, regRd = 0, sleepReq = 0, retReq = 0;
  logic sleepExec, isrEntry, retfieExec, cpuClkEn, sysClkEn, cpuCycleEn, watchdogClear;
  logic timeoutStatus, powerdownStatus, vectorToIsr, resumeInline, deviceReset, regLowPowerSleep;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  int failures = 0, checks = 0, cyc = 0;
  logic [7:0] d;
  logic vec, inl, wdc, mid, seen;
  int n;

  always #2 clk = ~clk;

  sdp_power_ctrl dut (.clk(clk), .rst_n(rst_n), .extResetPin_n(extResetPin_n),
    .brownoutEvent(brownoutEvent), .porEvent(porEvent), .sleepExec(sleepExec), .intPending(intPending),
    .globalIntEnable(globalIntEnable), .watchdogTimeout(watchdogTimeout), .isrEntry(isrEntry),
    .retfieExec(retfieExec), .inCircuitDebugState(inCircuitDebugState), .crystalOscMode(crystalOscMode),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn), .cpuCycleEn(cpuCycleEn), .watchdogClear(watchdogClear),
    .timeoutStatus(timeoutStatus), .powerdownStatus(powerdownStatus), .vectorToIsr(vectorToIsr),
    .resumeInline(resumeInline), .deviceReset(deviceReset), .regLowPowerSleep(regLowPowerSleep));

  sdp_core_model core (.clk(clk), .rst_n(rst_n), .sleepReq(sleepReq), .retReq(retReq), .cpuClkEn(cpuClkEn),
    .vectorToIsr(vectorToIsr), .sleepExec(sleepExec), .isrEntry(isrEntry), .retfieExec(retfieExec));

  // ****************************************
  // Helpers
  // ****************************************
  task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      report_and_stop;
    end
  end

  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) begin regAddr <= a; regWrData <= v; regWr <= 1'b1; end
    @(posedge clk) regWr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) begin regAddr <= a; regRd <= 1'b1; end
    @(posedge clk) regRd <= 1'b0;
    #1 v = regRdData;
  endtask

  task slp;
    @(posedge clk) sleepReq <= 1'b1;
    @(posedge clk) sleepReq <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Raises a wake cause and counts cycles until the CPU clock returns
  task wake(input logic wd);
    n = 0;
    mid = 1'b1;
    @(posedge clk) if (wd) watchdogTimeout <= 1'b1; else intPending <= 1'b1;
    @(posedge clk);
    #1;
    while (cpuClkEn !== 1'b1 && n < 3000) begin
      if (n == 600) mid = watchdogClear;
      @(posedge clk);
      #1 n++;
    end
    vec = vectorToIsr;
    inl = resumeInline;
    wdc = watchdogClear;
    @(posedge clk) begin intPending <= 1'b0; watchdogTimeout <= 1'b0; end
    #1;
  endtask

  task hit(input int k);
    seen = 1'b0;
    @(posedge clk) if (k == 0) extResetPin_n <= 1'b0; else if (k == 1) brownoutEvent <= 1'b1; else porEvent <= 1'b1;
    repeat (4) begin @(posedge clk); #1 seen |= deviceReset; end
    @(posedge clk) begin extResetPin_n <= 1'b1; brownoutEvent <= 1'b0; porEvent <= 1'b0; end
    repeat (6) @(posedge clk);
    #1;
    chk("deviceReset", seen, 1'b1);
    chk("cpuClkEnAfterReset", cpuClkEn, 1'b1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rd(`SDP_ADDR_REGULATOR, d); chk("regulatorReset", d, 8'h01);
    rd(`SDP_ADDR_DOZE, d); chk("dozeReset", d, 8'h00);
    rd(`SDP_ADDR_STATUS, d); chk("statusReset", d, 8'h03);
    rd(4'h5, d); chk("unmappedRead", d, 8'h00);
    wr(`SDP_ADDR_REGULATOR, 8'hff); rd(`SDP_ADDR_REGULATOR, d); chk("regulatorOnes", d, 8'h03);
    chk("lowPowerSel", regLowPowerSleep, 1'b1);
    wr(`SDP_ADDR_REGULATOR, 8'h01); rd(`SDP_ADDR_REGULATOR, d); chk("regulatorNormal", d, 8'h01);
    chk("normalSel", regLowPowerSleep, 1'b0);
    wr(`SDP_ADDR_DOZE, 8'hff); rd(`SDP_ADDR_DOZE, d); chk("dozeOnes", d, 8'hf7);
    wr(`SDP_ADDR_STATUS, 8'h00); rd(`SDP_ADDR_STATUS, d); chk("statusReadOnly", d, 8'h03);
    wr(`SDP_ADDR_DOZE, 8'h00);
    $display("test regs done");
  endtask

  task t_doze;
    for (int r = 0; r < 8; r++) begin
      wr(`SDP_ADDR_DOZE, 8'h40 | r[7:0]);
      repeat (4) @(posedge clk);
      n = 0;
      repeat (512) begin @(posedge clk); #1 if (cpuCycleEn === 1'b1) n++; end
      chk("dozeCycles", n[15:0], 16'(512 >> (r + 1)));
    end
    @(posedge clk) inCircuitDebugState <= 1'b1;
    repeat (2) @(posedge clk);
    n = 0;
    repeat (16) begin @(posedge clk); #1 if (cpuCycleEn === 1'b1) n++; end
    chk("debugFullSpeed", n[15:0], 16'h0010);
    rd(`SDP_ADDR_DOZE, d); chk("debugKeepsDoze", d, 8'h47);
    @(posedge clk) inCircuitDebugState <= 1'b0;
    wr(`SDP_ADDR_DOZE, 8'h00);
    $display("test doze done");
  endtask

  task t_sleep;
    @(posedge clk) intPending <= 1'b1;
    slp;
    chk("noopClk", cpuClkEn, 1'b1);
    chk("noopPd", powerdownStatus, 1'b1);
    chk("noopWdt", watchdogClear, 1'b0);
    @(posedge clk) begin intPending <= 1'b0; globalIntEnable <= 1'b1; end
    wr(`SDP_ADDR_DOZE, 8'h70);
    slp;
    chk("sleepCpuClk", cpuClkEn, 1'b0);
    chk("sleepSysClk", sysClkEn, 1'b0);
    chk("sleepWdt", watchdogClear, 1'b1);
    chk("sleepPd", powerdownStatus, 1'b0);
    chk("sleepTo", timeoutStatus, 1'b1);
    wake(1'b0);
    chk("wakeDelay", n[15:0], 16'h0000);
    chk("wakeVector", {vec, inl}, 2'b10);
    chk("wakeWdt", wdc, 1'b1);
    chk("wakeNoReset", deviceReset, 1'b0);
    repeat (2) @(posedge clk);
    rd(`SDP_ADDR_DOZE, d); chk("isrRecover", d, 8'h30);
    @(posedge clk) retReq <= 1'b1;
    @(posedge clk) retReq <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`SDP_ADDR_DOZE, d); chk("retDoze", d, 8'h70);
    wr(`SDP_ADDR_DOZE, 8'h40);
    slp;
    wake(1'b0);
    repeat (2) @(posedge clk);
    rd(`SDP_ADDR_DOZE, d); chk("isrNoRecover", d, 8'h40);
    wr(`SDP_ADDR_DOZE, 8'h00);
    @(posedge clk) globalIntEnable <= 1'b0;
    slp;
    wake(1'b0);
    chk("inlineWake", {vec, inl}, 2'b01);
    $display("test sleep done");
  endtask

  task t_idle_wdt;
    wr(`SDP_ADDR_DOZE, 8'h80);
    slp;
    chk("idleCpuClk", cpuClkEn, 1'b0);
    chk("idleSysClk", sysClkEn, 1'b1);
    wake(1'b0);
    chk("idleWake", {vec, inl, n[0]}, 3'b010);
    rd(`SDP_ADDR_DOZE, d); chk("idleKept", d, 8'h80);
    wr(`SDP_ADDR_DOZE, 8'h00);
    slp;
    wake(1'b1);
    chk("wdtWake", {vec, inl, wdc}, 3'b011);
    chk("wdtTo", timeoutStatus, 1'b0);
    chk("wdtPd", powerdownStatus, 1'b0);
    chk("wdtNoReset", deviceReset, 1'b0);
    $display("test idle and watchdog done");
  endtask

  task t_xtal;
    @(posedge clk) crystalOscMode <= 1'b1;
    slp;
    wake(1'b0);
    chk("startupWait", n[15:0], 16'(`SDP_OST_CYCLES));
    chk("startupWdtHeld", mid, 1'b1);
    wr(`SDP_ADDR_REGULATOR, 8'h03);
    slp;
    wake(1'b0);
    chk("stabiliseWait", n[15:0], 16'(`SDP_OST_CYCLES + `SDP_STAB_CYCLES));
    @(posedge clk) crystalOscMode <= 1'b0;
    slp;
    wake(1'b0);
    chk("stabiliseOnly", n[15:0], 16'(`SDP_STAB_CYCLES));
    wr(`SDP_ADDR_REGULATOR, 8'h01);
    $display("test crystal done");
  endtask

  task t_resets;
    wr(`SDP_ADDR_DOZE, 8'h80);
    hit(0);
    rd(`SDP_ADDR_DOZE, d); chk("pinKeepsIdle", d, 8'h80);
    slp;
    hit(1);
    rd(`SDP_ADDR_DOZE, d); chk("brownoutIdle", d, 8'h00);
    chk("resetPd", powerdownStatus, 1'b1);
    wr(`SDP_ADDR_DOZE, 8'h80);
    hit(2);
    rd(`SDP_ADDR_DOZE, d); chk("porIdle", d, 8'h00);
    $display("test resets done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_doze;
    t_sleep;
    t_idle_wdt;
    t_xtal;
    t_resets;
    report_and_stop;
  end
endmodule
